// file: design/uei_params.svh
// Constants for the endpoint interrupt and FIFO reset block.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef UEI_PARAMS_SVH
`define UEI_PARAMS_SVH

// ==========================================================
// Register map
`define UEI_ADDR_IRQ_EN   8'hc2
`define UEI_ADDR_IRQ_SUM  8'hf8
`define UEI_ADDR_FIFO_RST 8'hd5
`define UEI_ADDR_EP_SEL   8'hc7
`define UEI_ADDR_EP_STAT  8'hce

// ==========================================================
// Widths, masks and reset values
`define UEI_NUM_EP        7
`define UEI_SEL_W         3
`define UEI_SRC_W         5
`define UEI_RSV_MASK      8'h7f
`define UEI_ZERO_BYTE     8'h00
`define UEI_ZERO_EP       7'h00
`define UEI_ZERO_SEL      3'h0
`define UEI_ZERO_SRC      5'h00

// ==========================================================
// Endpoint status byte bit positions
`define UEI_STAT_IN_DONE  0
`define UEI_STAT_BANK0    1
`define UEI_STAT_SETUP    2
`define UEI_STAT_STALL    3
`define UEI_STAT_BANK1    6

`endif

// file: design/uei_pkg.sv
// Types shared by the endpoint interrupt and FIFO reset block.
// Assumes uei_params.svh is compiled alongside.
package uei_pkg;

	// ==========================================================
	// Status sources of one endpoint
	typedef struct packed {
		logic out_bank1_received;
		logic stall_sent_or_crc_error;
		logic setup_packet_received;
		logic out_bank0_received;
		logic in_packet_done;
	} uei_src_s;

	// ==========================================================
	// One register access from the bus port
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} uei_req_s;

endpackage

// file: design/uei_ep_status.sv
// Status sources of one endpoint: set by endpoint events, cleared by writing one.
// Assumes event pulses come from logic on the same clock.
`include "uei_params.svh"

module uei_ep_status (
	input  wire logic               clk,
	input  wire logic               sys_rst,
	input  wire uei_pkg::uei_src_s  evt,
	input  wire uei_pkg::uei_src_s  clr,
	output      uei_pkg::uei_src_s  status
);

	uei_pkg::uei_src_s status_ff;
	uei_pkg::uei_src_s nxt_status;

	// ==========================================================
	// Next status: set beats clear, setup clears the rest
	always_comb begin
		nxt_status = (status_ff & ~clr) | evt; // [RL10]
		if (evt.setup_packet_received) begin
			nxt_status = `UEI_ZERO_SRC; // [RL11]
			nxt_status.setup_packet_received = 1'b1; // [RL11]
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			status_ff <= `UEI_ZERO_SRC;
		end else begin
			status_ff <= nxt_status;
		end
	end

	assign status = status_ff;

endmodule

// file: design/uei_ctrl.sv
// Endpoint FIFO reset control, endpoint interrupt summary and interrupt request.
// Assumes a same-clock register port and same-clock endpoint event pulses.
//
// Function
// RL1: FIFO held in reset while bit set
// RL2: Firmware pulses reset bit after any reset
// RL3: Bit 7 reads zero, writes ignored
// RL4: Summary bit set when any source set
// RL5: Summary clears only when all sources clear
// RL6: Interrupt when summary and enable both set
// RL7: Enable bit allows or suppresses endpoint interrupts
// RL8: Summary register read-only at F8h
// RL9: Enable register read/write at C2h
// RL10: Transmit-complete source set on IN done
// RL11: Setup sets its bit, clears others
// RL12: Enable and FIFO reset bits reset zero
//
// Design decision made here: the strobed register port.
`include "uei_params.svh"

module uei_ctrl (
	input  wire logic                                   clk,
	input  wire logic                                   sys_rst,
	input  wire logic [7:0]                             reg_addr,
	input  wire logic [7:0]                             reg_wdata,
	input  wire logic                                   reg_wr,
	input  wire logic                                   reg_rd,
	input  wire uei_pkg::uei_src_s [`UEI_NUM_EP-1:0]    ep_evt,
	output      logic [7:0]                             reg_rdata,
	output      logic [`UEI_NUM_EP-1:0]                 ep_fifo_clear,
	output      logic                                   usb_irq
);

	uei_pkg::uei_req_s                  req;
	uei_pkg::uei_src_s [`UEI_NUM_EP-1:0] ep_stat;
	uei_pkg::uei_src_s [`UEI_NUM_EP-1:0] ep_clr;
	logic [`UEI_NUM_EP-1:0]             irq_summary;
	logic [`UEI_NUM_EP-1:0]             irq_enable_ff;
	logic [`UEI_NUM_EP-1:0]             fifo_clear_ff;
	logic [`UEI_SEL_W-1:0]              ep_sel_ff;
	logic [7:0]                         rdata_ff;
	logic                               irq_ff;
	logic [7:0]                         nxt_rdata;
	logic                               sel_ok;

	assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
	assign sel_ok = (ep_sel_ff < `UEI_SEL_W'(`UEI_NUM_EP));

	// ==========================================================
	// Helpers
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	function automatic logic [7:0] stat_byte(input uei_pkg::uei_src_s s);
		stat_byte = `UEI_ZERO_BYTE;
		stat_byte[`UEI_STAT_IN_DONE] = s.in_packet_done;
		stat_byte[`UEI_STAT_BANK0]   = s.out_bank0_received;
		stat_byte[`UEI_STAT_SETUP]   = s.setup_packet_received;
		stat_byte[`UEI_STAT_STALL]   = s.stall_sent_or_crc_error;
		stat_byte[`UEI_STAT_BANK1]   = s.out_bank1_received;
	endfunction

	function automatic uei_pkg::uei_src_s stat_src(input logic [7:0] b);
		stat_src = `UEI_ZERO_SRC;
		stat_src.in_packet_done          = b[`UEI_STAT_IN_DONE];
		stat_src.out_bank0_received      = b[`UEI_STAT_BANK0];
		stat_src.setup_packet_received   = b[`UEI_STAT_SETUP];
		stat_src.stall_sent_or_crc_error = b[`UEI_STAT_STALL];
		stat_src.out_bank1_received      = b[`UEI_STAT_BANK1];
	endfunction

	// ==========================================================
	// Per-endpoint status and summary
	genvar g;
	generate
		for (g = 0; g < `UEI_NUM_EP; g++) begin : g_ep
			always_comb begin
				ep_clr[g] = `UEI_ZERO_SRC;
				if (req.wr && hit(req.addr, `UEI_ADDR_EP_STAT) && sel_ok
				    && (ep_sel_ff == `UEI_SEL_W'(g))) begin
					ep_clr[g] = stat_src(req.wdata);
				end
			end

			uei_ep_status u_stat (
				.clk     (clk),
				.sys_rst (sys_rst),
				.evt     (ep_evt[g]),
				.clr     (ep_clr[g]),
				.status  (ep_stat[g])
			);

			assign irq_summary[g] = |ep_stat[g]; // [RL4] [RL5]
		end
	endgenerate

	// ==========================================================
	// Writable registers
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_enable_ff <= `UEI_ZERO_EP; // [RL12]
		end else if (req.wr && hit(req.addr, `UEI_ADDR_IRQ_EN)) begin
			irq_enable_ff <= req.wdata[`UEI_NUM_EP-1:0]; // [RL9] [RL3]
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			fifo_clear_ff <= `UEI_ZERO_EP; // [RL12]
		end else if (req.wr && hit(req.addr, `UEI_ADDR_FIFO_RST)) begin
			fifo_clear_ff <= req.wdata[`UEI_NUM_EP-1:0]; // [RL1] [RL3]
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ep_sel_ff <= `UEI_ZERO_SEL;
		end else if (req.wr && hit(req.addr, `UEI_ADDR_EP_SEL)) begin
			ep_sel_ff <= req.wdata[`UEI_SEL_W-1:0];
		end
	end

	// ==========================================================
	// Read data, valid one cycle after the read strobe
	always_comb begin
		nxt_rdata = `UEI_ZERO_BYTE;
		if (req.rd) begin
			if (hit(req.addr, `UEI_ADDR_IRQ_EN)) begin
				nxt_rdata = {1'b0, irq_enable_ff} & `UEI_RSV_MASK; // [RL3]
			end else if (hit(req.addr, `UEI_ADDR_IRQ_SUM)) begin
				nxt_rdata = {1'b0, irq_summary} & `UEI_RSV_MASK; // [RL8] [RL3]
			end else if (hit(req.addr, `UEI_ADDR_FIFO_RST)) begin
				nxt_rdata = {1'b0, fifo_clear_ff} & `UEI_RSV_MASK; // [RL3]
			end else if (hit(req.addr, `UEI_ADDR_EP_SEL)) begin
				nxt_rdata = {5'h00, ep_sel_ff};
			end else if (hit(req.addr, `UEI_ADDR_EP_STAT) && sel_ok) begin
				nxt_rdata = stat_byte(ep_stat[ep_sel_ff]);
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_ff <= `UEI_ZERO_BYTE;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	// ==========================================================
	// Interrupt request
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(irq_summary & irq_enable_ff); // [RL6] [RL7]
		end
	end

	assign reg_rdata     = rdata_ff;
	assign ep_fifo_clear = fifo_clear_ff;
	assign usb_irq       = irq_ff;

endmodule

// file: dv/uei_ctrl_checker.sv
// Port checker for the endpoint interrupt and FIFO reset block.
// Assumes it is bound to every instance of uei_ctrl.
`include "uei_params.svh"

module uei_ctrl_checker (
	input wire logic                                clk,
	input wire logic                                sys_rst,
	input wire logic [7:0]                          reg_addr,
	input wire logic [7:0]                          reg_wdata,
	input wire logic                                reg_wr,
	input wire logic                                reg_rd,
	input wire uei_pkg::uei_src_s [`UEI_NUM_EP-1:0] ep_evt,
	input wire logic [7:0]                          reg_rdata,
	input wire logic [`UEI_NUM_EP-1:0]              ep_fifo_clear,
	input wire logic                                usb_irq
);
	logic [6:0] en_ff;
	logic [6:0] evt_any;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	// ==========================================================
	// Shadow of the enable register
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			en_ff <= 7'h00;
		else if (reg_wr && reg_addr == 8'hc2)
			en_ff <= reg_wdata[6:0];
	end
	always_comb begin
		for (int i = 0; i < 7; i++)
			evt_any[i] = |ep_evt[i];
	end

	// ==========================================================
	// Properties
	property p_rsv_bit; reg_rdata[7] == 1'b0; endproperty
	property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
	property p_fifo_set;
		reg_wr && reg_addr == 8'hd5 |=> ep_fifo_clear == $past(reg_wdata[6:0]);
	endproperty
	property p_fifo_hold; !(reg_wr && reg_addr == 8'hd5) |=> $stable(ep_fifo_clear); endproperty
	property p_rd_en; reg_rd && reg_addr == 8'hc2 |=> reg_rdata == {1'b0, $past(en_ff)}; endproperty
	property p_rd_fifo;
		reg_rd && reg_addr == 8'hd5 |=> reg_rdata == {1'b0, $past(ep_fifo_clear)};
	endproperty
	property p_irq_mask; (en_ff == 7'h00) [*2] |-> !usb_irq; endproperty
	property p_evt_irq; (|(evt_any & en_ff)) && !reg_wr |-> ##2 usb_irq; endproperty

	a_rsv_bit: assert property (p_rsv_bit) else $error("bit 7 read as one");
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer");
	a_fifo_set: assert property (p_fifo_set) else $error("fifo reset not written");
	a_fifo_hold: assert property (p_fifo_hold) else $error("fifo reset changed");
	a_rd_en: assert property (p_rd_en) else $error("enable read wrong");
	a_rd_fifo: assert property (p_rd_fifo) else $error("fifo reset read wrong");
	a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
	a_evt_irq: assert property (p_evt_irq) else $error("irq missing");

	c_irq: cover property ($rose(usb_irq));
	c_fifo: cover property (reg_wr && reg_addr == 8'hd5);
	c_sum: cover property (reg_rd && reg_addr == 8'hf8);
endmodule

bind uei_ctrl uei_ctrl_checker u_chk (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .ep_evt(ep_evt),
	.reg_rdata(reg_rdata), .ep_fifo_clear(ep_fifo_clear), .usb_irq(usb_irq));

// file: dv/tb.sv
// Self-checking bench for the endpoint interrupt and FIFO reset block.
// Assumes the design files and the port checker are compiled before it.
`include "uei_params.svh"

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic                                clk = 1'b0;
	logic                                sys_rst = 1'b1;
	logic [7:0]                          reg_addr = 8'h00;
	logic [7:0]                          reg_wdata = 8'h00;
	logic                                reg_wr = 1'b0;
	logic                                reg_rd = 1'b0;
	uei_pkg::uei_src_s [`UEI_NUM_EP-1:0] ep_evt = 35'h0;
	logic [7:0]                          reg_rdata;
	logic [6:0]                          ep_fifo_clear;
	logic                                usb_irq;
	int                                  bad_count = 0;
	int                                  total_checks = 0;
	always #25 clk = ~clk;

	uei_ctrl dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .ep_evt(ep_evt), .reg_rdata(reg_rdata),
		.ep_fifo_clear(ep_fifo_clear), .usb_irq(usb_irq));

	// ==========================================================
	// Access tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	task automatic evt(input int n, input logic [4:0] v);
		@(posedge clk);
		ep_evt[n] <= v;
		@(posedge clk);
		ep_evt <= 35'h0;
		@(posedge clk);
		#1;
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ==========================================================
	// Tests
	initial begin
		#100000;
		bad_count++;
		conclude();
	end
	initial begin
		int k;
		logic [7:0] sb;
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		rd(8'hc2, 8'h00);
		rd(8'hd5, 8'h00);
		chk({7'h00, usb_irq}, 8'h00);
		$display("test reset done");
		wr(8'hc2, 8'h7f);
		rd(8'hc2, 8'h7f);
		wr(8'hf8, 8'h7f);
		rd(8'hf8, 8'h00);
		wr(8'hd5, 8'h7f);
		chk({1'b0, ep_fifo_clear}, 8'h7f);
		wr(8'hd5, 8'h00);
		chk({1'b0, ep_fifo_clear}, 8'h00);
		wr(8'hc2, 8'h00);
		$display("test registers done");
		evt(0, 5'h01);
		chk({7'h00, usb_irq}, 8'h00);
		wr(8'hc2, 8'h01);
		@(posedge clk);
		#1 chk({7'h00, usb_irq}, 8'h01);
		wr(8'hc7, 8'h00);
		evt(0, 5'h02);
		evt(0, 5'h04);
		rd(8'hce, 8'h04);
		wr(8'hce, 8'h04);
		rd(8'hf8, 8'h00);
		chk({7'h00, usb_irq}, 8'h00);
		$display("test mask done");
		for (int n = 0; n < 7; n++) begin
			k = (n % 3 == 0) ? 1 : (n % 3 == 1) ? 3 : 4;
			sb = (k == 4) ? 8'h40 : 8'h01 << k;
			wr(8'hc2, 8'h01 << n);
			evt(n, 5'h01 | (5'h01 << k));
			chk({7'h00, usb_irq}, 8'h01);
			rd(8'hf8, 8'h01 << n);
			wr(8'hc7, 8'(n));
			rd(8'hce, 8'h01 | sb);
			wr(8'hce, 8'h01);
			rd(8'hf8, 8'h01 << n);
			wr(8'hce, sb);
			rd(8'hf8, 8'h00);
			chk({7'h00, usb_irq}, 8'h00);
		end
		$display("test endpoints done");
		conclude();
	end
endmodule
